// file: aprp_pkg.sv
// Purpose: shared constants and types for the parallel result port
// Assumes: ref_clk at 250 MHz, synchronous active-high reset
// Notes: conversion core is modelled by a fixed-length timer per channel
package aprp_pkg;
    localparam int APRP_DATA_W = 14;
    localparam int APRP_CHANS = 4;
    localparam int APRP_CLK_MHZ = 250;
    // per-channel conversion time in ns, and done pulse width in ns
    localparam int APRP_CONV_NS = 2400;
    localparam int APRP_CONV_CYC = (APRP_CONV_NS * APRP_CLK_MHZ + 999) / 1000;
    localparam int APRP_DONE_NS = 40;
    localparam int APRP_DONE_CYC = (APRP_DONE_NS * APRP_CLK_MHZ) / 1000;
    localparam logic [3:0] APRP_SEL_RESET = 4'hf;
    localparam int APRP_CNT_W = 12;
    typedef enum logic [1:0] {
        APRP_IDLE = 2'b00,
        APRP_CONV = 2'b01,
        APRP_NEXT = 2'b10
    } aprp_state_t;
endpackage : aprp_pkg

// file: aprp_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module aprp_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk, // clock
    input wire logic reset, // synchronous reset
    input wire logic [W-1:0] d, // asynchronous level
    output logic [W-1:0] q // synchronised level
);
    logic [W-1:0] meta;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : aprp_sync

// file: aprp_port.sv
// Purpose: host-facing parallel port: result reads, channel select writes, sequencing
// Assumes: host strobes are asynchronous pins; results come from the core as parallel words
// Notes: strobes are sampled after synchronisation, so the bus turns on two to three cycles late
`timescale 1ns/1ps
module aprp_port
    import aprp_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic reset, // synchronous reset
    input wire logic sample_start_n, // conversion start pin, rising edge starts
    input wire logic sw_select, // low: pins choose channels, high: register
    input wire logic chan1_include_pin, // channel 1 include pin
    input wire logic chan2_include_pin, // channel 2 include pin
    input wire logic chan3_include_pin, // channel 3 include pin
    input wire logic chan4_include_pin, // channel 4 include pin
    input wire logic cs_n, // chip select pin
    input wire logic rd_n, // read strobe pin
    input wire logic wr_n, // write strobe pin
    input wire logic unipolar, // high on unipolar range variant
    input wire logic [APRP_CHANS*APRP_DATA_W-1:0] core_result, // raw offset-binary words
    input wire logic [3:0] bus_low_in, // low four bus lines as seen at the pins
    output logic [APRP_DATA_W-1:0] bus_out, // bus drive value, bus_bit_msb on top
    output logic bus_high_oe, // enable for bus lines 13 to 4
    output logic bus_low_oe, // enable for bus lines 3 to 0
    output logic conv_done_n, // per-conversion done pulse, active low
    output logic busy // sequence in progress
);
    typedef struct packed {
        aprp_state_t state;
        logic [3:0] sel_reg;
        logic [3:0] pending;
        logic [1:0] chan;
        logic [APRP_CNT_W-1:0] cnt;
        logic [APRP_CNT_W-1:0] done_cnt;
        logic start_d;
        logic wr_d;
        logic [1:0] rd_chan;
        logic [APRP_DATA_W-1:0] bus_out;
        logic bus_high_oe;
        logic bus_low_oe;
        logic conv_done_n;
        logic busy;
    } aprp_regs_t;

    aprp_regs_t r;
    aprp_regs_t next_r;
    logic [9:0] pins_s;
    logic [3:0] pin_sel;
    logic start_s;
    logic mode_s;
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic [3:0] low_s;
    logic [APRP_DATA_W-1:0] coded [APRP_CHANS];

    aprp_sync #(.W(10)) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        // active-low pins go in inverted so the sync reset value reads as idle;
        // otherwise a false start edge and a false write follow every reset
        .d({~sample_start_n, sw_select, chan4_include_pin, chan3_include_pin,
            chan2_include_pin, chan1_include_pin, ~cs_n, ~rd_n, ~wr_n, unipolar}),
        .q(pins_s)
    );
    aprp_sync #(.W(4)) u_sync_low (
        .ref_clk(ref_clk),
        .reset(reset),
        .d(bus_low_in),
        .q(low_s)
    );

    assign start_s = ~pins_s[9];
    assign mode_s = pins_s[8];
    assign pin_sel = pins_s[7:4];
    assign cs_s = pins_s[3];
    assign rd_s = pins_s[2];
    assign wr_s = pins_s[1];

    genvar gi;
    generate
        for (gi = 0; gi < APRP_CHANS; gi++) begin : g_code
            logic [APRP_DATA_W-1:0] raw;
            assign raw = core_result[gi*APRP_DATA_W +: APRP_DATA_W];
            // offset binary to two's complement is a flip of the top bit
            assign coded[gi] = pins_s[0] ? raw : {~raw[APRP_DATA_W-1], raw[APRP_DATA_W-2:0]};
        end
    endgenerate

    always_comb begin
        next_r = r;
        next_r.start_d = start_s;
        next_r.wr_d = cs_s & wr_s;
        // load on the trailing edge of the write so the data lines have settled
        if (r.wr_d && !(cs_s && wr_s)) begin
            next_r.sel_reg = low_s;
        end
        if (r.done_cnt != '0) begin
            next_r.done_cnt = r.done_cnt - 1'b1;
        end
        next_r.conv_done_n = !(r.done_cnt > 1);
        case (r.state)
            APRP_IDLE: begin
                if (start_s && !r.start_d) begin
                    next_r.pending = mode_s ? r.sel_reg : pin_sel;
                    next_r.busy = 1'b1;
                    next_r.chan = 2'd0;
                    next_r.state = APRP_NEXT;
                end
            end
            APRP_NEXT: begin
                // skip excluded channels; an empty selection ends at once
                if (r.pending == 4'h0) begin
                    next_r.busy = 1'b0;
                    next_r.state = APRP_IDLE;
                end else if (r.pending[r.chan]) begin
                    next_r.cnt = APRP_CNT_W'(APRP_CONV_CYC - 1);
                    next_r.state = APRP_CONV;
                end else begin
                    next_r.chan = r.chan + 2'd1;
                end
            end
            APRP_CONV: begin
                if (r.cnt == '0) begin
                    next_r.pending[r.chan] = 1'b0;
                    next_r.rd_chan = r.chan;
                    next_r.done_cnt = APRP_CNT_W'(APRP_DONE_CYC + 1);
                    next_r.state = APRP_NEXT;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            default: begin
                next_r.state = APRP_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
        // reads give the latest finished channel result
        next_r.bus_out = coded[r.rd_chan];
        next_r.bus_high_oe = cs_s & rd_s;
        next_r.bus_low_oe = cs_s & rd_s & ~wr_s;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
            r.state <= APRP_IDLE;
            r.sel_reg <= APRP_SEL_RESET;
            r.conv_done_n <= 1'b1;
            r.start_d <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus_out = r.bus_out;
    assign bus_high_oe = r.bus_high_oe;
    assign bus_low_oe = r.bus_low_oe;
    assign conv_done_n = r.conv_done_n;
    assign busy = r.busy;

    property p_busy_rise;
        @(posedge ref_clk) disable iff (reset)
        (r.state == APRP_IDLE && start_s && !r.start_d) |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

    property p_busy_hold;
        @(posedge ref_clk) disable iff (reset)
        (r.state == APRP_CONV) |-> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy low mid sequence");

    property p_latch;
        @(posedge ref_clk) disable iff (reset)
        (r.state == APRP_IDLE && start_s && !r.start_d && !mode_s) |=> r.pending == $past(pin_sel);
    endproperty
    a_latch: assert property (p_latch) else $error("pin selection not latched");

    property p_latch_sw;
        @(posedge ref_clk) disable iff (reset)
        (r.state == APRP_IDLE && start_s && !r.start_d && mode_s) |=> r.pending == $past(r.sel_reg);
    endproperty
    a_latch_sw: assert property (p_latch_sw) else $error("register selection not latched");

    property p_done_pulse;
        @(posedge ref_clk) disable iff (reset)
        (r.state == APRP_CONV && r.cnt == '0) |=> ##1 !conv_done_n;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("no done pulse");

    property p_done_idle;
        @(posedge ref_clk) disable iff (reset)
        (r.state == APRP_IDLE && r.done_cnt == '0) |=> conv_done_n;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done low while idle");

    property p_high_oe;
        @(posedge ref_clk) disable iff (reset)
        bus_high_oe |-> $past(cs_s & rd_s);
    endproperty
    a_high_oe: assert property (p_high_oe) else $error("bus driven outside read");

    property p_low_oe;
        @(posedge ref_clk) disable iff (reset)
        bus_low_oe |-> bus_high_oe && !$past(wr_s);
    endproperty
    a_low_oe: assert property (p_low_oe) else $error("low lines driven during write");

    property p_write;
        @(posedge ref_clk) disable iff (reset)
        (r.wr_d && !(cs_s && wr_s)) |=> r.sel_reg == $past(low_s);
    endproperty
    a_write: assert property (p_write) else $error("select register not loaded");
endmodule : aprp_port

// file: aprp_host.sv
// Purpose: host side of the low four bus lines
// Assumes: host drives them only in its own write cycle
// Notes: a floating line shows the inverse of its last level
`timescale 1ns/1ps
module aprp_host (
    input wire logic ref_clk, // clock
    input wire logic host_en, // host drives low lines
    input wire logic [3:0] host_data, // host write value
    input wire logic [3:0] dev_data, // device drive value
    input wire logic dev_oe, // device drives low lines
    output logic [3:0] wire_val // resolved level
);
    logic [3:0] last = 4'h0;
    always @(posedge ref_clk) last <= wire_val;
    // a clash shows as unknown so it cannot pass for data
    assign wire_val = (dev_oe && host_en) ? 4'hx : dev_oe ? dev_data :
        host_en ? host_data : ~last;
endmodule : aprp_host

// file: aprp_tb.sv
// Purpose: random and corner sequences through the parallel result port
// Assumes: strobes held past the two-flop sync
// Notes: every result is read during its done pulse
`timescale 1ns/1ps
module tb;
    import aprp_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, start_n = 1'b1, sw_sel = 1'b0, uni = 1'b0;
    logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, host_en = 1'b0, done_q = 1'b1;
    logic [3:0] pins = 4'h0, host_data = 4'h0, low_in;
    logic [3:0] corner [4] = '{4'hf, 4'h1, 4'h8, 4'h6};
    logic [APRP_CHANS*APRP_DATA_W-1:0] core = '0;
    logic [APRP_DATA_W-1:0] bus_out;
    logic hi_oe, lo_oe, done_n, busy;
    int n_fail = 0, num_checks = 0, n_done = 0;
    int seed = 32'hfea7;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        done_q <= done_n;
        if (done_q === 1'b1 && done_n === 1'b0) n_done++;
    end
    aprp_port i_dut (.ref_clk(ref_clk), .reset(reset), .sample_start_n(start_n),
        .sw_select(sw_sel), .chan1_include_pin(pins[0]), .chan2_include_pin(pins[1]),
        .chan3_include_pin(pins[2]), .chan4_include_pin(pins[3]), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .unipolar(uni), .core_result(core),
        .bus_low_in(low_in), .bus_out(bus_out), .bus_high_oe(hi_oe),
        .bus_low_oe(lo_oe), .conv_done_n(done_n), .busy(busy));
    aprp_host i_host (.ref_clk(ref_clk), .host_en(host_en), .host_data(host_data),
        .dev_data(bus_out[3:0]), .dev_oe(lo_oe), .wire_val(low_in));
    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    function automatic logic sig(input int k);
        return (k == 0) ? hi_oe : (k == 1) ? done_n : busy;
    endfunction : sig
    task automatic wait_sig(input int k, input logic v, input int lim);
        int n;
        for (n = 0; n < lim && sig(k) !== v; n++) @(negedge ref_clk);
        if (sig(k) !== v) begin
            chk("wait", 14'(v), 14'(sig(k)));
            finish_test();
        end
    endtask : wait_sig
    function automatic logic [13:0] expect_code(input int ch);
        logic [13:0] raw;
        raw = core[ch*APRP_DATA_W +: APRP_DATA_W];
        return uni ? raw : {~raw[13], raw[12:0]};
    endfunction : expect_code
    task automatic read_chk(input int ch);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        wait_sig(0, 1'b1, 10);
        chk("low enable", 14'h1, 14'(lo_oe));
        chk("result", expect_code(ch), bus_out);
        @(posedge ref_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("enables idle", 14'h0, {12'h0, hi_oe, lo_oe});
    endtask : read_chk
    task automatic write_sel(input logic [3:0] v);
        @(posedge ref_clk);
        host_en <= 1'b1;
        host_data <= v;
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("enables on write", 14'h0, {12'h0, hi_oe, lo_oe});
        @(posedge ref_clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        host_en <= 1'b0;
    endtask : write_sel
    task automatic run_seq(input logic [3:0] sel);
        int d0;
        d0 = n_done;
        @(posedge ref_clk);
        start_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        start_n <= 1'b1;
        wait_sig(2, 1'b1, 6);
        repeat (8) @(posedge ref_clk);
        pins <= ~pins;
        for (int ch = 0; ch < APRP_CHANS; ch++) begin
            if (sel[ch]) begin
                wait_sig(1, 1'b0, 700);
                if ((sel >> (ch + 1)) != 4'h0) chk("busy", 14'h1, 14'(busy));
                read_chk(ch);
                wait_sig(1, 1'b1, 12);
            end
        end
        wait_sig(2, 1'b0, 20);
        chk("done pulses", 14'($countones(sel)), 14'(n_done - d0));
    endtask : run_seq
    initial begin
        logic [3:0] sel;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("idle outputs", 14'h1, {10'h0, busy, hi_oe, lo_oe, done_n});
        for (int i = 0; i < 8; i++) begin
            sel = (i < 4) ? corner[i] : 4'($random(seed));
            if (sel == 4'h0) sel = 4'h2;
            @(posedge ref_clk);
            core <= 56'({$random(seed), $random(seed)});
            uni <= 1'($random(seed));
            sw_sel <= i[0];
            pins <= i[0] ? ~sel : sel;
            if (i[0]) write_sel(sel);
            run_seq(sel);
        end
        // an empty pin selection gives a short busy and no done pulse
        @(posedge ref_clk);
        sw_sel <= 1'b0;
        pins <= 4'h0;
        run_seq(4'h0);
        finish_test();
    end
endmodule : tb
